// ==== hdl/osf_top.sv ====
// Output sample formatter: AHB-Lite registers, 2-D addressing and memory writes.
//
// Functional notes
// - Accept one 24-bit complex sample per clock.
// - Start is 16-bit byte address, zero is bank0.
// - Width bit selects 16-bit or 32-bit words.
// - Real-only bit drops the imaginary part.
// - Both bits clear: 16-bit real plus imaginary.
// - Sample address advances by the stride.
// - Iteration start advances by iteration offset.
// - Iteration count 3 gives four iterations.
// - Writes per iteration: count plus one minus skip.
// - Leading skip samples are dropped before writes.
// - Interleaved four-channel pattern works as expected.
// - Bit-reversed FFT output lands in natural order.
// - 16-bit: drop shift LSBs, saturate upper bits.
// - 32-bit: extend top, zero-pad bottom bits.
// - Signed mode: sign copy, signed saturation.
// - Iterations repeat back-to-back without triggers.
// - Conjugate bit negates the imaginary part.
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "osf_cfg.svh"

module osf_top import osf_pkg::*; #(
	parameter int ADDR_W = 16,
	parameter int SAMP_W = 24
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic core_valid,
	input wire logic [SAMP_W-1:0] core_re,
	input wire logic [SAMP_W-1:0] core_im,
	output logic core_ready,
	output logic mem_we,
	output logic [ADDR_W-1:0] mem_addr,
	output logic [63:0] mem_wdata,
	output logic [1:0] mem_wsize
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************

	// Bus pipeline: pending write and its offset.
	logic wr_pend_r;
	logic [11:0] wr_addr_r;
	logic [31:0] hrdata_r;
	// Parameter-set registers.
	logic out_word_width_sel_r;
	logic out_real_only_r;
	logic out_signed_mode_r;
	logic out_conjugate_r;
	logic bitrev_en_r;
	logic [3:0] fft_log2_r;
	logic [ADDR_W-1:0] dest_start_address_r;
	logic [15:0] dest_sample_stride_r;
	logic [15:0] dest_iteration_offset_r;
	logic [11:0] dest_sample_count_r;
	logic [9:0] dest_skip_count_r;
	logic [11:0] iteration_count_r;
	logic [7:0] out_shift_scale_r;
	logic [11:0] core_len_r;
	// Engine state.
	osf_state_type state_r;
	logic done_r;
	logic [11:0] arr_idx_r;
	logic [11:0] iter_idx_r;
	logic [ADDR_W-1:0] iter_base_r;
	// Output pipeline.
	logic mem_we_r;
	logic [ADDR_W-1:0] mem_addr_r;
	logic [63:0] mem_wdata_r;
	logic [1:0] mem_wsize_r;
	// Combinational helpers.
	logic start_req;
	logic accept;
	logic iter_end;
	logic [11:0] nat_idx;
	logic wr_hit;
	logic [27:0] prod;
	logic [ADDR_W-1:0] addr_calc;
	logic [3:0] shift4;
	logic [SAMP_W:0] re_ext;
	logic [SAMP_W:0] im_ext;
	logic [SAMP_W:0] im_fix;
	logic [31:0] re_word;
	logic [31:0] im_word;

	// ****************************************************************
	// Functions.
	// ****************************************************************

	// Reverses the low log2 bits of an arrival index.
	function automatic logic [11:0] bit_reverse(input logic [11:0] idx, input logic [3:0] nb);
		logic [11:0] rev;
		rev = '0;
		for (int i = 0; i < `OSF_IDX_W; i++) begin
			rev[i] = idx[`OSF_IDX_W-1-i];
		end
		return rev >> (4'(`OSF_IDX_W) - nb);
	endfunction

	// Returns the value that a register read shows.
	function automatic logic [31:0] read_mux(input logic [11:0] off);
		logic [31:0] v;
		v = `OSF_RST_ZERO;
		unique case (off)
			`OSF_OFF_CTRL: begin
				v[`OSF_CTRL_WIDTH32] = out_word_width_sel_r;
				v[`OSF_CTRL_REAL] = out_real_only_r;
				v[`OSF_CTRL_SIGNED] = out_signed_mode_r;
				v[`OSF_CTRL_CONJ] = out_conjugate_r;
				v[`OSF_CTRL_BITREV] = bitrev_en_r;
				v[`OSF_CTRL_LOG2_HI:`OSF_CTRL_LOG2_LO] = fft_log2_r;
			end
			`OSF_OFF_DEST_START: v[ADDR_W-1:0] = dest_start_address_r;
			`OSF_OFF_STRIDE: v[15:0] = dest_sample_stride_r;
			`OSF_OFF_ITER_OFFSET: v[15:0] = dest_iteration_offset_r;
			`OSF_OFF_SAMPLE_COUNT: v[11:0] = dest_sample_count_r;
			`OSF_OFF_SKIP: v[9:0] = dest_skip_count_r;
			`OSF_OFF_ITER_COUNT: v[11:0] = iteration_count_r;
			`OSF_OFF_SHIFT: v[7:0] = out_shift_scale_r;
			`OSF_OFF_CORE_LEN: v[11:0] = core_len_r;
			`OSF_OFF_STATUS: begin
				v[`OSF_STAT_BUSY] = (state_r == osf_st_run);
				v[`OSF_STAT_DONE] = done_r;
				v[`OSF_STAT_ITER_LO+11:`OSF_STAT_ITER_LO] = iter_idx_r;
			end
			default: v = `OSF_RST_ZERO;
		endcase
		return v;
	endfunction

	// ****************************************************************
	// AHB-Lite slave: zero wait states, always OKAY.
	// ****************************************************************

	// Address phase capture; read data is registered for the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
			hrdata_r <= `OSF_RST_ZERO;
		end else if (hsel && hready && htrans[1] && hsize == `OSF_HSIZE_WORD) begin
			wr_pend_r <= hwrite;
			wr_addr_r <= haddr[11:0];
			if (!hwrite) begin
				hrdata_r <= read_mux(haddr[11:0]);
			end
		end else begin
			wr_pend_r <= 1'b0;
		end
	end

	// A start request only counts while the engine is idle.
	assign start_req = wr_pend_r && wr_addr_r == `OSF_OFF_CTRL && hwdata[`OSF_CTRL_START];

	// Data phase writes into the parameter set.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_word_width_sel_r <= 1'b0;
			out_real_only_r <= 1'b0;
			out_signed_mode_r <= `OSF_RST_SIGNED;
			out_conjugate_r <= 1'b0;
			bitrev_en_r <= 1'b0;
			fft_log2_r <= 4'h0;
			dest_start_address_r <= 16'h0000;
			dest_sample_stride_r <= 16'h0000;
			dest_iteration_offset_r <= 16'h0000;
			dest_sample_count_r <= 12'h000;
			dest_skip_count_r <= 10'h000;
			iteration_count_r <= 12'h000;
			out_shift_scale_r <= 8'h00;
			core_len_r <= 12'h000;
		end else if (wr_pend_r) begin
			unique case (wr_addr_r)
				`OSF_OFF_CTRL: begin
					out_word_width_sel_r <= hwdata[`OSF_CTRL_WIDTH32];
					out_real_only_r <= hwdata[`OSF_CTRL_REAL];
					out_signed_mode_r <= hwdata[`OSF_CTRL_SIGNED];
					out_conjugate_r <= hwdata[`OSF_CTRL_CONJ];
					bitrev_en_r <= hwdata[`OSF_CTRL_BITREV];
					fft_log2_r <= hwdata[`OSF_CTRL_LOG2_HI:`OSF_CTRL_LOG2_LO];
				end
				`OSF_OFF_DEST_START: dest_start_address_r <= hwdata[ADDR_W-1:0];
				`OSF_OFF_STRIDE: dest_sample_stride_r <= hwdata[15:0];
				`OSF_OFF_ITER_OFFSET: dest_iteration_offset_r <= hwdata[15:0];
				`OSF_OFF_SAMPLE_COUNT: dest_sample_count_r <= hwdata[11:0];
				`OSF_OFF_SKIP: dest_skip_count_r <= hwdata[9:0];
				`OSF_OFF_ITER_COUNT: iteration_count_r <= hwdata[11:0];
				`OSF_OFF_SHIFT: out_shift_scale_r <= hwdata[7:0];
				`OSF_OFF_CORE_LEN: core_len_r <= hwdata[11:0];
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// Addressing and sample formatting.
	// ****************************************************************

	// Index mapping, write window and 2-D address.
	always_comb begin
		accept = (state_r == osf_st_run) && core_valid;
		iter_end = accept && arr_idx_r == core_len_r;
		// Natural bin position of a bit-reversed arrival.
		nat_idx = bitrev_en_r ? bit_reverse(arr_idx_r, fft_log2_r) : arr_idx_r;
		// Leading skip bins and trailing bins past the count are dropped.
		wr_hit = nat_idx >= 12'(dest_skip_count_r) && nat_idx <= dest_sample_count_r;
		prod = nat_idx * dest_sample_stride_r;
		addr_calc = iter_base_r + prod[ADDR_W-1:0];
		shift4 = (out_shift_scale_r > 8'h08) ? `OSF_SCALE_MAX : out_shift_scale_r[3:0];
		re_ext = out_signed_mode_r ? {core_re[SAMP_W-1], core_re} : {1'b0, core_re};
		im_ext = out_signed_mode_r ? {core_im[SAMP_W-1], core_im} : {1'b0, core_im};
		// Negation of the imaginary part for complex output.
		im_fix = (out_conjugate_r && !out_real_only_r) ? -im_ext : im_ext;
	end

	// Real component scaler.
	osf_scaler #(.IN_W(SAMP_W + 1)) u_scale_re (
		.sample_in(re_ext),
		.shift_in(shift4),
		.signed_mode(out_signed_mode_r),
		.width32(out_word_width_sel_r),
		.word_out(re_word)
	);

	// Imaginary component scaler.
	osf_scaler #(.IN_W(SAMP_W + 1)) u_scale_im (
		.sample_in(im_fix),
		.shift_in(shift4),
		.signed_mode(out_signed_mode_r),
		.width32(out_word_width_sel_r),
		.word_out(im_word)
	);

	// ****************************************************************
	// Engine sequencing.
	// ****************************************************************

	// Runs all iterations back-to-back once started.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= osf_st_idle;
			done_r <= 1'b0;
			arr_idx_r <= 12'h000;
			iter_idx_r <= 12'h000;
			iter_base_r <= 16'h0000;
		end else begin
			unique case (state_r)
				osf_st_idle: begin
					if (start_req) begin
						state_r <= osf_st_run;
						done_r <= 1'b0;
						arr_idx_r <= 12'h000;
						iter_idx_r <= 12'h000;
						iter_base_r <= dest_start_address_r;
					end
				end
				osf_st_run: begin
					if (iter_end) begin
						arr_idx_r <= 12'h000;
						iter_base_r <= iter_base_r + dest_iteration_offset_r;
						if (iter_idx_r == iteration_count_r) begin
							state_r <= osf_st_idle;
							done_r <= 1'b1;
						end else begin
							iter_idx_r <= iter_idx_r + 12'h001;
						end
					end else if (accept) begin
						arr_idx_r <= arr_idx_r + 12'h001;
					end
				end
			endcase
		end
	end

	// Registers one memory write per accepted sample inside the window.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_we_r <= 1'b0;
			mem_addr_r <= 16'h0000;
			mem_wdata_r <= 64'h0000_0000_0000_0000;
			mem_wsize_r <= `OSF_WSIZE_2B;
		end else begin
			mem_we_r <= accept && wr_hit;
			if (accept && wr_hit) begin
				mem_addr_r <= addr_calc;
				if (out_real_only_r) begin
					// Only the real word is stored.
					mem_wdata_r <= {32'h0000_0000, re_word};
					mem_wsize_r <= out_word_width_sel_r ? `OSF_WSIZE_4B : `OSF_WSIZE_2B;
				end else if (out_word_width_sel_r) begin
					mem_wdata_r <= {im_word, re_word};
					mem_wsize_r <= `OSF_WSIZE_8B;
				end else begin
					mem_wdata_r <= {32'h0000_0000, im_word[15:0], re_word[15:0]};
					mem_wsize_r <= `OSF_WSIZE_4B;
				end
			end
		end
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign hrdata = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign core_ready = (state_r == osf_st_run);
	assign mem_we = mem_we_r;
	assign mem_addr = mem_addr_r;
	assign mem_wdata = mem_wdata_r;
	assign mem_wsize = mem_wsize_r;

	// ****************************************************************
	// Assertions and covers.
	// ****************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	write_address_a: assert property (accept && wr_hit |=> mem_we && mem_addr == $past(addr_calc))
		else $error("write address does not follow the 2-D pattern");
	skip_drop_a: assert property (accept && nat_idx < 12'(dest_skip_count_r) |=> !mem_we)
		else $error("skipped leading sample was written");
	count_drop_a: assert property (accept && nat_idx > dest_sample_count_r |=> !mem_we)
		else $error("sample beyond the count was written");
	real_only_a: assert property (accept && wr_hit && out_real_only_r
		&& !out_word_width_sel_r |=> mem_wsize == `OSF_WSIZE_2B)
		else $error("real-only 16-bit write has wrong size");
	cplx_pair_a: assert property (accept && wr_hit && !out_real_only_r
		&& !out_word_width_sel_r |=> mem_wsize == `OSF_WSIZE_4B)
		else $error("complex 16-bit pair has wrong size");
	iter_step_a: assert property (iter_end && iter_idx_r != iteration_count_r |=>
		state_r == osf_st_run && iter_base_r == $past(iter_base_r) + $past(dest_iteration_offset_r))
		else $error("iteration start did not advance by the offset");
	last_iter_a: assert property (iter_end && iter_idx_r == iteration_count_r
		|=> state_r == osf_st_idle && done_r)
		else $error("engine did not stop after the last iteration");
	signed_sat_a: assert property (accept && wr_hit && out_signed_mode_r
		&& !out_word_width_sel_r && !core_re[SAMP_W-1] && (core_re >> shift4) > 24'h00_7FFF
		|=> mem_wdata[15:0] == 16'h7FFF)
		else $error("positive overflow did not saturate");
	run_steady_a: assert property (state_r == osf_st_run && !iter_end |=> state_r == osf_st_run)
		else $error("engine left run before the last iteration");

	bitrev_write_c: cover property (accept && wr_hit && bitrev_en_r && nat_idx != arr_idx_r);
	final_iter_c: cover property (iter_end && iter_idx_r == iteration_count_r && iter_idx_r != 0);
	skip_seen_c: cover property (accept && nat_idx < 12'(dest_skip_count_r));
	wide_cplx_c: cover property (mem_we && mem_wsize == `OSF_WSIZE_8B);

endmodule

// ==== hdl/osf_cfg.svh ====
// Constants of the output sample formatter: offsets, fields, resets and codes.
`ifndef OSF_CFG_SVH
`define OSF_CFG_SVH

// ****************************************************************
// Register offsets, decoded from haddr[11:0].
// ****************************************************************
`define OSF_OFF_CTRL 12'h000
`define OSF_OFF_DEST_START 12'h004
`define OSF_OFF_STRIDE 12'h008
`define OSF_OFF_ITER_OFFSET 12'h00C
`define OSF_OFF_SAMPLE_COUNT 12'h010
`define OSF_OFF_SKIP 12'h014
`define OSF_OFF_ITER_COUNT 12'h018
`define OSF_OFF_SHIFT 12'h01C
`define OSF_OFF_CORE_LEN 12'h020
`define OSF_OFF_STATUS 12'h024

// ****************************************************************
// Control register fields.
// ****************************************************************
`define OSF_CTRL_START 0
`define OSF_CTRL_WIDTH32 1
`define OSF_CTRL_REAL 2
`define OSF_CTRL_SIGNED 3
`define OSF_CTRL_CONJ 4
`define OSF_CTRL_BITREV 5
`define OSF_CTRL_LOG2_LO 8
`define OSF_CTRL_LOG2_HI 11

// ****************************************************************
// Status register fields.
// ****************************************************************
`define OSF_STAT_BUSY 0
`define OSF_STAT_DONE 1
`define OSF_STAT_ITER_LO 16

// ****************************************************************
// Reset values, bus codes, write sizes and scaling limits.
// ****************************************************************
`define OSF_RST_ZERO 32'h0000_0000
`define OSF_RST_SIGNED 1'b1
`define OSF_HSIZE_WORD 3'h2
`define OSF_WSIZE_2B 2'h1
`define OSF_WSIZE_4B 2'h2
`define OSF_WSIZE_8B 2'h3
`define OSF_SCALE_MAX 4'h8
`define OSF_IDX_W 12

`endif

// ==== hdl/osf_pkg.sv ====
// Types shared by the output sample formatter.
package osf_pkg;

	// ****************************************************************
	// Engine states.
	// ****************************************************************
	typedef enum logic {osf_st_idle, osf_st_run} osf_state_type;

endpackage

// ==== hdl/osf_scaler.sv ====
// Shift-scaling of one 24-bit component into a 16-bit or 32-bit word.
`timescale 1ns/1ps
`include "osf_cfg.svh"

module osf_scaler #(
	parameter int IN_W = 25
) (
	input wire logic [IN_W-1:0] sample_in,
	input wire logic [3:0] shift_in,
	input wire logic signed_mode,
	input wire logic width32,
	output logic [31:0] word_out
);

	// Component as a two's complement value, right-shifted and left-shifted views.
	logic signed [IN_W-1:0] s_val;
	logic signed [IN_W-1:0] shr;
	logic [3:0] lsh;
	logic signed [39:0] wide;

	// ****************************************************************
	// Scaling and saturation.
	// ****************************************************************

	// Unsigned samples arrive zero-extended, so one signed path serves both modes.
	always_comb begin
		s_val = $signed(sample_in);
		shr = s_val >>> shift_in;
		lsh = `OSF_SCALE_MAX - shift_in;
		wide = 40'(s_val) <<< lsh;
		if (width32) begin
			// Top gains shift bits by extension, bottom gains zeros.
			word_out = wide[31:0];
		end else if (signed_mode) begin
			// Signed clipping of the upper bits.
			if (shr > 32'sh0000_7FFF) begin
				word_out = 32'h0000_7FFF;
			end else if (shr < -32'sh0000_8000) begin
				word_out = 32'h0000_8000;
			end else begin
				word_out = {16'h0000, shr[15:0]};
			end
		end else begin
			// Unsigned clipping saturates to the largest 16-bit value.
			if (shr < 32'sh0000_0000) begin
				word_out = 32'h0000_0000;
			end else if (shr > 32'sh0000_FFFF) begin
				word_out = 32'h0000_FFFF;
			end else begin
				word_out = {16'h0000, shr[15:0]};
			end
		end
	end

endmodule

// ==== bench/osf_core_model.sv ====
// Model of the computation core's sample stream and of the local memory.
`timescale 1ns/1ps

module osf_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	input wire logic slow,
	input wire logic [15:0] total,
	input wire logic core_ready,
	output logic core_valid,
	output logic [23:0] core_re,
	output logic [23:0] core_im,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [63:0] mem_wdata,
	input wire logic [1:0] mem_wsize
);
	// Sample tables filled by the bench, and the memory image as written.
	logic [23:0] re_tab [0:1023];
	logic [23:0] im_tab [0:1023];
	logic [63:0] mem [int];
	logic [1:0] msz [int];
	int idx;
	int wr_count;
	int cyc;
	int first_cyc;
	int last_cyc;
	logic hold_off;

	// ****************************************************************
	// Sample stream.
	// ****************************************************************
	// A sample is offered only while the engine runs, every cycle or every other one.
	// Idle data lines flip each cycle, so a stale value can never be taken for a sample.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx = 0;
			hold_off = 1'b0;
			core_valid <= 1'b0;
			core_re <= 24'h000000;
			core_im <= 24'h000000;
		end else begin
			if (go) begin
				idx = 0;
			end else if (core_valid && core_ready) begin
				idx = idx + 1;
			end
			hold_off = slow && !hold_off;
			if (!go && idx < int'(total) && core_ready && !hold_off) begin
				core_valid <= 1'b1;
				core_re <= re_tab[idx];
				core_im <= im_tab[idx];
			end else begin
				core_valid <= 1'b0;
				core_re <= ~core_re;
				core_im <= ~core_im;
			end
		end
	end

	// ****************************************************************
	// Memory capture.
	// ****************************************************************
	// Every write is stored by byte address with its size; the cycles of the first and last writes are kept.
	always @(posedge hclk) begin
		cyc = cyc + 1;
		if (go) begin
			mem.delete();
			msz.delete();
			wr_count = 0;
		end else if (mem_we) begin
			mem[int'(mem_addr)] = mem_wdata;
			msz[int'(mem_addr)] = mem_wsize;
			if (wr_count == 0) first_cyc = cyc;
			last_cyc = cyc;
			wr_count = wr_count + 1;
		end
	end
endmodule

// ==== bench/tb_output_sample_formatter.sv ====
// Self-checking bench of the output sample formatter.
`timescale 1ns/1ps
`include "osf_cfg.svh"

module tb_output_sample_formatter;
	// Bus, stream and memory signals; the single slave drives the bus ready.
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic core_valid, core_ready, mem_we;
	logic [23:0] core_re, core_im;
	logic [15:0] mem_addr;
	logic [63:0] mem_wdata;
	logic [1:0] mem_wsize;
	logic go = 1'b0;
	logic slow = 1'b0;
	logic [15:0] total = 16'h0;
	int checks = 0;
	int fail_count = 0;

	always #2 hclk = ~hclk;

	osf_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.core_valid(core_valid), .core_re(core_re), .core_im(core_im),
		.core_ready(core_ready), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_wsize(mem_wsize));

	osf_core_model CORE (.hclk(hclk), .hresetn(hresetn), .go(go), .slow(slow),
		.total(total), .core_ready(core_ready), .core_valid(core_valid),
		.core_re(core_re), .core_im(core_im), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_wsize(mem_wsize));

	// ****************************************************************
	// Reporting and bus access.
	// ****************************************************************
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Masked compare; an unknown bit under the mask never matches.
	task automatic chk(input logic [63:0] got, exp, mask);
		checks++;
		if ((got & mask) !== (exp & mask)) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got & mask, exp);
		end
	endtask

	// Waits for a rising edge with hready high; a hang ends the run.
	task automatic wait_ready();
		int t;
		t = 0;
		do begin
			@(posedge hclk);
			t++;
		end while (hreadyout !== 1'b1 && t < 50);
		if (hreadyout !== 1'b1) begin
			fail_count++;
			print_verdict();
		end
	endtask

	// One single word transfer: address phase, then data phase.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= `OSF_HSIZE_WORD;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	// Loads one sample into the core model's tables.
	task automatic put(input int k, input logic [23:0] re, im);
		CORE.re_tab[k] = re;
		CORE.im_tab[k] = im;
	endtask

	// ****************************************************************
	// Expected words.
	// ****************************************************************
	function automatic logic [31:0] sref(longint x, int sh, bit sg, bit w32);
		if (w32) return 32'(x <<< (8 - sh));
		x = x >>> sh;
		if (sg && x > 32767) x = 32767;
		if (sg && x < -32768) x = -32768;
		if (!sg && x > 65535) x = 65535;
		return 32'(x);
	endfunction

	function automatic int rev(int n, int b);
		int r;
		r = 0;
		for (int j = 0; j < b; j++) r = r | (((n >> j) & 1) << (b - 1 - j));
		return r;
	endfunction

	// Runs one job, then checks every expected write and the write count.
	task automatic run_job(input logic [31:0] c, input logic [15:0] st, stride, ioff,
		input int cnt, skip, iters, sh, clen, input logic lazy);
		logic [31:0] v, r, q;
		logic [63:0] e, m;
		logic [1:0] sz;
		longint re, im;
		int k, x;
		logic [15:0] ad;
		wr(`OSF_OFF_DEST_START, {16'h0, st});
		wr(`OSF_OFF_STRIDE, {16'h0, stride});
		wr(`OSF_OFF_ITER_OFFSET, {16'h0, ioff});
		wr(`OSF_OFF_SAMPLE_COUNT, cnt);
		wr(`OSF_OFF_SKIP, skip);
		wr(`OSF_OFF_ITER_COUNT, iters);
		wr(`OSF_OFF_SHIFT, sh);
		wr(`OSF_OFF_CORE_LEN, clen);
		@(posedge hclk);
		go <= 1'b1;
		slow <= lazy;
		total <= 16'((clen + 1) * (iters + 1));
		@(posedge hclk);
		go <= 1'b0;
		wr(`OSF_OFF_CTRL, c | 32'h1);
		k = 0;
		do begin
			bus(1'b0, `OSF_OFF_STATUS, 32'h0, v);
			k++;
		end while (v[1] !== 1'b1 && k < 3000);
		chk({63'h0, v[1]}, 64'h1, 64'h1);
		if (v[1] !== 1'b1) begin
			print_verdict();
		end
		for (int i = 0; i <= iters; i++) begin
			for (int n = skip; n <= cnt; n++) begin
				x = i * (clen + 1) + (c[5] ? rev(n, int'(c[11:8])) : n);
				ad = 16'(st + i * ioff + n * stride);
				re = c[3] ? longint'($signed(CORE.re_tab[x])) : longint'(CORE.re_tab[x]);
				im = c[3] ? longint'($signed(CORE.im_tab[x])) : longint'(CORE.im_tab[x]);
				if (c[4] && !c[2]) im = -im;
				r = sref(re, sh, c[3], c[1]);
				q = sref(im, sh, c[3], c[1]);
				e = c[1] ? {q, r} : {32'h0, q[15:0], r[15:0]};
				m = c[2] ? (c[1] ? 64'hFFFF_FFFF : 64'hFFFF) : (c[1] ? '1 : 64'hFFFF_FFFF);
				sz = c[2] ? (c[1] ? 2'h2 : 2'h1) : (c[1] ? 2'h3 : 2'h2);
				chk(CORE.mem.exists(int'(ad)) ? CORE.mem[int'(ad)] : 'x, e, m);
				chk(CORE.msz.exists(int'(ad)) ? CORE.msz[int'(ad)] : 'x, sz, 64'h3);
			end
		end
		chk(64'(CORE.wr_count), 64'((iters + 1) * (cnt + 1 - skip)), '1);
	endtask

	// ****************************************************************
	// Tests.
	// ****************************************************************
	initial begin
		logic [31:0] v;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// Register reset values, field widths and an unmapped word.
		bus(1'b0, `OSF_OFF_CTRL, 32'h0, v);
		chk(v, 64'h8, '1);
		for (int a = 4; a <= 36; a += 4) begin
			bus(1'b0, 12'(a), 32'h0, v);
			chk(v, 64'h0, '1);
		end
		wr(`OSF_OFF_DEST_START, 32'hFFFF_FFFF);
		bus(1'b0, `OSF_OFF_DEST_START, 32'h0, v);
		chk(v, 64'hFFFF, '1);
		wr(12'h040, 32'hFFFF_FFFF);
		bus(1'b0, 12'h040, 32'h0, v);
		chk(v, 64'h0, '1);
		chk({63'h0, hresp}, 64'h0, 64'h1);
		$display("test registers done");
		// Four interleaved channels of 128 complex words in bank three, stalled stream.
		for (int k = 0; k < 512; k++) begin
			CORE.re_tab[k] = 24'((k / 128) * 256 + k % 128);
			CORE.im_tab[k] = 24'(-((k / 128) * 256 + k % 128));
		end
		run_job(32'h8, 16'hC040, 16'h10, 16'h4, 127, 0, 3, 0, 127, 1'b1);
		$display("test interleave done");
		// Leading skip and trailing drop, 32-bit real signed words.
		for (int k = 0; k < 8; k++) begin
			CORE.re_tab[k] = 24'(k - 4);
			CORE.im_tab[k] = 24'(k);
		end
		run_job(32'hE, 16'h1000, 16'h8, 16'h0, 5, 2, 0, 8, 7, 1'b0);
		$display("test skip done");
		// Signed and unsigned 16-bit saturation, real only.
		put(0, 24'h7FFFFF, 24'h000000);
		put(1, 24'h800000, 24'h000000);
		put(2, 24'h000123, 24'h000000);
		put(3, 24'hFFFFF0, 24'h000000);
		run_job(32'hC, 16'h4000, 16'h2, 16'h0, 3, 0, 0, 3, 3, 1'b0);
		put(0, 24'h800000, 24'h000000);
		put(1, 24'h0000AB, 24'h000000);
		put(2, 24'h010000, 24'h000000);
		put(3, 24'h00FFFF, 24'h000000);
		run_job(32'h4, 16'h4100, 16'h2, 16'h0, 3, 0, 0, 0, 3, 1'b0);
		$display("test saturation done");
		// 32-bit complex words with the imaginary part negated.
		put(0, 24'h800000, 24'h000010);
		put(1, 24'h000001, 24'h7FFFFF);
		run_job(32'h1A, 16'h2000, 16'h8, 16'h0, 1, 0, 0, 3, 1, 1'b0);
		$display("test conjugate done");
		// Bit-reversed arrival over two iterations, written in natural order.
		for (int k = 0; k < 16; k++) begin
			CORE.re_tab[k] = 24'(k * 3);
			CORE.im_tab[k] = 24'(k);
		end
		run_job(32'h328, 16'h8000, 16'h4, 16'h20, 7, 0, 1, 0, 7, 1'b0);
		chk(64'(CORE.last_cyc - CORE.first_cyc), 64'd15, '1);
		$display("test bit reverse done");
		print_verdict();
	end
endmodule
